// >>> core/smp_sleep_ctrl.sv
// sleep mode power controller with axi4-lite register access
// Summary of operation
// - code 000 idle stops cpu and flash
// - code 001 adc mode stops io cpu flash
// - code 010 power-down halts all generated clocks
// - code 011 power-save keeps timer2 running
// - 110/111 standby keeps oscillator, six-cycle wake, if crystal selected
// - adc mode wakes only on listed sources
// - power-down wakes only on listed sources
// - outside idle external pins wake by level only
// - idle wakes on external and internal interrupts
// - adc mode timer2 runs only when asynchronous
// - idle/adc entry starts adc conversion if enabled
// - any interrupt in the mode's wake mask wakes from sleep
// - core halted four cycles after start-up
// - register file and sram left untouched
// - reset during sleep restarts at reset vector
// - power-down wake waits fuse-selected start-up time
// - brown-out disable only in deep modes
// - detector off in sleep, back on wake
// - detector disabled stretches wake to 60 us
// - bit 6 of mcu control disables detector
// - detector disable bit written by timed sequence
`timescale 1ns/100ps
module smp_sleep_ctrl
  import smp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16,
  parameter int unsigned STARTUP_CYC_0 = 16,
  parameter int unsigned STARTUP_CYC_1 = 256,
  parameter int unsigned STARTUP_CYC_2 = 1024,
  parameter int unsigned STARTUP_CYC_3 = 16384,
  parameter int unsigned BOD_WAKE_CYCLES = BOD_WAKE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sleep_instr,
  input wire logic [WAKE_W-1:0] wake_src,
  input wire logic sys_reset_req,
  input wire logic timer2_async,
  input wire logic adc_enabled,
  input wire logic bod_fuse_enabled,
  input wire logic ext_crystal_sel,
  input wire logic [1:0] clock_select_fuses,
  output logic cpu_clk_en,
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic async_clk_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic bod_enable,
  output logic adc_conv_start,
  output logic core_resume,
  output logic core_reset_vector
);

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m != 3'h4) && (m != 3'h5);
  endfunction

  // standby codes fall back to the deep modes without a crystal
  function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic xtal);
    eff_mode = m;
    if (!xtal && m == MODE_STBY) begin
      eff_mode = MODE_PDOWN;
    end
    if (!xtal && m == MODE_XSTBY) begin
      eff_mode = MODE_PSAVE;
    end
  endfunction

  function automatic logic [WAKE_W-1:0] wake_mask(input logic [2:0] m, input logic t2a);
    case (m)
      MODE_IDLE: wake_mask = WMASK_IDLE;
      MODE_ADC: begin
        wake_mask = WMASK_ADC;
        wake_mask[WS_TIMER2] = t2a;
      end
      MODE_PSAVE, MODE_XSTBY: wake_mask = WMASK_PSAVE;
      default: wake_mask = WMASK_PDOWN;
    endcase
  endfunction

  function automatic logic [DOM_W-1:0] dom_of(input smp_state_e s, input logic [2:0] m, input logic t2a);
    logic [DOM_W-1:0] d;
    logic t2;
    d = DOM_ACTIVE;
    t2 = 1'b1;
    if (s == SMP_WAKE || s == SMP_HALT) begin
      d = DOM_WAKE;
    end else if (s == SMP_SLEEP) begin
      case (m)
        MODE_IDLE: d = DOM_IDLE;
        MODE_ADC: d = DOM_ADC;
        MODE_PSAVE: d = DOM_PSAVE;
        MODE_STBY: begin
          d = DOM_STBY;
          t2 = 1'b0;
        end
        MODE_XSTBY: d = DOM_STBY;
        default: begin
          d = DOM_PDOWN;
          t2 = 1'b0;
        end
      endcase
    end
    dom_of = (t2 && t2a) ? (d | DOM_T2_ASYNC) : d;
  endfunction

  function automatic logic [CNT_W-1:0] wake_len(input logic [2:0] m, input logic boff, input logic [1:0] sel);
    logic [CNT_W-1:0] n;
    case (m)
      MODE_PDOWN, MODE_PSAVE: begin
        case (sel)
          2'h0: n = CNT_W'(STARTUP_CYC_0);
          2'h1: n = CNT_W'(STARTUP_CYC_1);
          2'h2: n = CNT_W'(STARTUP_CYC_2);
          default: n = CNT_W'(STARTUP_CYC_3);
        endcase
      end
      MODE_STBY, MODE_XSTBY: n = CNT_W'(STANDBY_WAKE_CYC);
      default: n = CNT_W'(SHORT_WAKE_CYC);
    endcase
    if (boff && n < CNT_W'(BOD_WAKE_CYCLES)) begin
      n = CNT_W'(BOD_WAKE_CYCLES);
    end
    wake_len = n;
  endfunction

  // register and bus state
  logic aw_hold, w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic sleep_enable_bit;
  logic [2:0] sleep_mode_select;
  logic brownout_sleep_disable_bit;
  logic [2:0] tws_cnt;
  logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic next_se;
  logic [2:0] next_sm;
  logic next_brownout_sleep_disable_bit;
  logic [2:0] next_tws_cnt;

  // power sequencer state
  smp_state_e state, next_state;
  logic [2:0] mode, next_mode;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic bod_off, next_bod_off;
  logic from_reset, next_from_reset;
  logic [DOM_W-1:0] dom, next_dom;
  logic next_bod_en, next_adc_start, next_resume, next_restart;
  logic wake_hit;

  function automatic logic [31:0] read_reg(input logic [ADDR_W-1:0] a);
    read_reg = 32'h0000_0000;
    if (a == ADDR_W'(OFF_SLEEP_CTRL)) begin
      read_reg[SE_BIT] = sleep_enable_bit;
      read_reg[SM_LSB +: 3] = sleep_mode_select;
    end else if (a == ADDR_W'(OFF_MCU_CTRL)) begin
      read_reg[BROWNOUT_SLEEP_DISABLE_BIT_BIT] = brownout_sleep_disable_bit;
      read_reg[BODSE_BIT] = (tws_cnt != 3'h0);
    end else if (a == ADDR_W'(OFF_STATUS)) begin
      read_reg[ST_STATE_LSB +: 2] = state;
      read_reg[ST_FROM_RESET_BIT] = from_reset;
      read_reg[ST_BOD_OFF_BIT] = bod_off;
      read_reg[ST_MODE_LSB +: 3] = mode;
      read_reg[ST_DOM_LSB +: DOM_W] = dom;
    end
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == ADDR_W'(OFF_SLEEP_CTRL)) || (a == ADDR_W'(OFF_MCU_CTRL)) || (a == ADDR_W'(OFF_STATUS));
  endfunction

  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign arready = !rvalid;

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_se = sleep_enable_bit;
    next_sm = sleep_mode_select;
    next_brownout_sleep_disable_bit = brownout_sleep_disable_bit;
    next_tws_cnt = (tws_cnt != 3'h0) ? tws_cnt - 3'h1 : 3'h0;
    if (awvalid && awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_hold = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (w_strb[0] && aw_addr == ADDR_W'(OFF_SLEEP_CTRL)) begin
        next_se = w_data[SE_BIT];
        next_sm = w_data[SM_LSB +: 3];
      end
      if (w_strb[0] && aw_addr == ADDR_W'(OFF_MCU_CTRL)) begin
        if (w_data[BODSE_BIT] && w_data[BROWNOUT_SLEEP_DISABLE_BIT_BIT]) begin
          next_tws_cnt = 3'(TIMED_WINDOW_CYC);
        end else if (tws_cnt != 3'h0 && !w_data[BODSE_BIT]) begin
          next_brownout_sleep_disable_bit = w_data[BROWNOUT_SLEEP_DISABLE_BIT_BIT];
          next_tws_cnt = 3'h0;
        end
      end
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = read_reg(araddr);
      next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      sleep_enable_bit <= 1'b0;
      sleep_mode_select <= MODE_IDLE;
      brownout_sleep_disable_bit <= 1'b0;
      tws_cnt <= 3'h0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      sleep_enable_bit <= next_se;
      sleep_mode_select <= next_sm;
      brownout_sleep_disable_bit <= next_brownout_sleep_disable_bit;
      tws_cnt <= next_tws_cnt;
    end
  end

  assign wake_hit = |(wake_src & wake_mask(mode, timer2_async));

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cnt = cnt;
    next_bod_off = bod_off;
    next_from_reset = from_reset;
    next_adc_start = 1'b0;
    next_resume = 1'b0;
    next_restart = 1'b0;
    case (state)
      SMP_ACTIVE: begin
        if (sleep_instr && sleep_enable_bit && mode_ok(sleep_mode_select)) begin
          next_state = SMP_SLEEP;
          next_mode = eff_mode(sleep_mode_select, ext_crystal_sel);
          next_bod_off = brownout_sleep_disable_bit && bod_fuse_enabled
            && (next_mode != MODE_IDLE) && (next_mode != MODE_ADC);
          next_adc_start = adc_enabled && (next_mode == MODE_IDLE || next_mode == MODE_ADC);
        end
      end
      SMP_SLEEP: begin
        if (sys_reset_req || wake_hit) begin
          next_state = SMP_WAKE;
          next_from_reset = sys_reset_req;
          next_cnt = wake_len(mode, bod_off, clock_select_fuses) - CNT_W'(1);
          next_bod_off = 1'b0;
        end
      end
      SMP_WAKE: begin
        if (cnt == '0) begin
          if (from_reset) begin
            next_state = SMP_ACTIVE;
            next_restart = 1'b1;
            next_from_reset = 1'b0;
          end else begin
            next_state = SMP_HALT;
            next_cnt = CNT_W'(HALT_CYC - 1);
          end
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      SMP_HALT: begin
        if (cnt == '0) begin
          next_state = SMP_ACTIVE;
          next_resume = 1'b1;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: next_state = SMP_ACTIVE;
    endcase
    next_dom = dom_of(next_state, next_mode, timer2_async);
    next_bod_en = bod_fuse_enabled && !next_bod_off;
  end

  // no path here clears core storage; resume only releases the clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SMP_ACTIVE;
      mode <= MODE_IDLE;
      cnt <= '0;
      bod_off <= 1'b0;
      from_reset <= 1'b0;
      dom <= DOM_ACTIVE;
      bod_enable <= 1'b0;
      adc_conv_start <= 1'b0;
      core_resume <= 1'b0;
      core_reset_vector <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cnt <= next_cnt;
      bod_off <= next_bod_off;
      from_reset <= next_from_reset;
      dom <= next_dom;
      bod_enable <= next_bod_en;
      adc_conv_start <= next_adc_start;
      core_resume <= next_resume;
      core_reset_vector <= next_restart;
    end
  end

  assign cpu_clk_en = dom[0];
  assign flash_clk_en = dom[1];
  assign io_clk_en = dom[2];
  assign adc_clk_en = dom[3];
  assign async_clk_en = dom[4];
  assign main_osc_en = dom[5];
  assign timer_osc_en = dom[6];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_conv;
    state == SMP_ACTIVE && sleep_instr && sleep_enable_bit && adc_enabled
      && (sleep_mode_select == MODE_IDLE || sleep_mode_select == MODE_ADC);
  endsequence
  sequence s_halt_start;
    state == SMP_WAKE && cnt == '0 && !from_reset;
  endsequence

  AST_NOP_SE_CLEAR: assert property (state == SMP_ACTIVE && sleep_instr && !sleep_enable_bit |=> state == SMP_ACTIVE && dom == $past(dom)) else $error("sleep with enable clear changed state");
  AST_IDLE_CLOCKS: assert property (state == SMP_SLEEP && mode == MODE_IDLE |-> !cpu_clk_en && !flash_clk_en && io_clk_en && adc_clk_en) else $error("idle clock domains wrong");
  AST_ADC_CLOCKS: assert property (state == SMP_SLEEP && mode == MODE_ADC |-> !io_clk_en && !cpu_clk_en && adc_clk_en && main_osc_en) else $error("adc mode clock domains wrong");
  AST_PDOWN_CLOCKS: assert property (state == SMP_SLEEP && mode == MODE_PDOWN |-> dom == DOM_PDOWN) else $error("power-down left a clock running");
  AST_HALT_FOUR: assert property (s_halt_start |=> (state == SMP_HALT && !cpu_clk_en)[*4] ##1 (state == SMP_ACTIVE && core_resume)) else $error("halt after wake not four cycles");
  AST_CONV_START: assert property (s_enter_conv |=> adc_conv_start ##1 !adc_conv_start) else $error("conversion not started on entry");
  AST_BOD_KEPT: assert property (state == SMP_SLEEP && (mode == MODE_IDLE || mode == MODE_ADC) && $past(bod_fuse_enabled) |-> bod_enable) else $error("detector off in shallow mode");
  AST_BOD_BACK: assert property (state == SMP_WAKE |-> bod_enable == $past(bod_fuse_enabled)) else $error("detector not back on wake");
  AST_EDGE_NO_WAKE: assert property (state == SMP_SLEEP && mode != MODE_IDLE && !sys_reset_req && wake_src == 9'h040 |=> state == SMP_SLEEP) else $error("edge interrupt woke deep mode");
  AST_STANDBY_SIX: assert property (state == SMP_SLEEP && mode == MODE_STBY && !bod_off && wake_hit && !sys_reset_req |=> (state == SMP_WAKE)[*6] ##1 state == SMP_HALT) else $error("standby wake not six cycles");
  AST_RESET_WAKE: assert property (state == SMP_SLEEP && sys_reset_req |=> state == SMP_WAKE && from_reset) else $error("reset did not wake");

endmodule

// >>> pkg/smp_pkg.sv
// shared constants and types for the sleep mode power controller
package smp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] OFF_MCU_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // field positions
  localparam int SE_BIT = 0;
  localparam int SM_LSB = 1;
  localparam int BODSE_BIT = 5;
  localparam int BROWNOUT_SLEEP_DISABLE_BIT_BIT = 6;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FROM_RESET_BIT = 2;
  localparam int ST_BOD_OFF_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_DOM_LSB = 8;
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY = 3'h6;
  localparam logic [2:0] MODE_XSTBY = 3'h7;
  // wake source vector: 0 adc done, 1 twi match, 2 timer2, 3 store ready,
  // 4 watchdog irq, 5 ext level, 6 ext edge, 7 pin change, 8 other irq
  localparam int WAKE_W = 9;
  localparam int WS_TIMER2 = 2;
  localparam logic [8:0] WMASK_IDLE = 9'h1ff;
  localparam logic [8:0] WMASK_ADC = 9'h0bf;
  localparam logic [8:0] WMASK_PDOWN = 9'h0b2;
  localparam logic [8:0] WMASK_PSAVE = 9'h0b6;
  // domain vector: 6 timer osc, 5 main osc, 4 async, 3 adc, 2 io, 1 flash, 0 cpu
  localparam int DOM_W = 7;
  localparam logic [6:0] DOM_ACTIVE = 7'h3f;
  localparam logic [6:0] DOM_WAKE = 7'h3c;
  localparam logic [6:0] DOM_IDLE = 7'h3c;
  localparam logic [6:0] DOM_ADC = 7'h38;
  localparam logic [6:0] DOM_PDOWN = 7'h00;
  localparam logic [6:0] DOM_PSAVE = 7'h10;
  localparam logic [6:0] DOM_STBY = 7'h20;
  localparam logic [6:0] DOM_T2_ASYNC = 7'h50;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int BOD_WAKE_US = 60;
  localparam int BOD_WAKE_CYC = BOD_WAKE_US * CLK_MHZ;
  localparam int HALT_CYC = 4;
  localparam int STANDBY_WAKE_CYC = 6;
  localparam int TIMED_WINDOW_CYC = 4;
  localparam int SHORT_WAKE_CYC = 1;
  typedef enum logic [1:0] {
    SMP_ACTIVE = 2'h0,
    SMP_SLEEP = 2'h1,
    SMP_WAKE = 2'h3,
    SMP_HALT = 2'h2
  } smp_state_e;
endpackage

// >>> test/smp_core_model.sv
// core side model: issues sleep and holds wake and reset requests
`timescale 1ns/100ps
module smp_core_model
  import smp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_resume,
  input wire logic core_reset_vector,
  output logic sleep_instr,
  output logic [WAKE_W-1:0] wake_src,
  output logic sys_reset_req
);
  initial begin
    sleep_instr = 1'b0;
    wake_src = '0;
    sys_reset_req = 1'b0;
  end
  // one-cycle sleep instruction, issued after the enable bit is written
  task automatic do_sleep();
    @(posedge aclk);
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
  endtask
  task automatic irq(input logic [WAKE_W-1:0] v, input logic rq);
    @(posedge aclk);
    wake_src <= v;
    sys_reset_req <= rq;
  endtask
  // levels stay up until the core answers, then drop
  always @(posedge aclk) begin
    if (core_resume || core_reset_vector || !aresetn) begin
      wake_src <= '0;
      sys_reset_req <= 1'b0;
    end
  end
endmodule

// >>> test/tb.sv
// self-checking bench for the sleep mode power controller
`timescale 1ns/100ps
module tb;
  import smp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic timer2_async = 1'b0;
  logic adc_enabled = 1'b1;
  logic bod_fuse_enabled = 1'b1;
  logic ext_crystal_sel = 1'b1;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] clock_select_fuses = 2'h2;
  logic awready, wready, bvalid, arready, rvalid, sleep_instr, sys_reset_req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [WAKE_W-1:0] wake_src;
  logic cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, async_clk_en, main_osc_en, timer_osc_en;
  logic bod_enable, adc_conv_start, core_resume, core_reset_vector;
  logic [6:0] dom;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [2:0] TM [8] = '{MODE_IDLE, MODE_ADC, MODE_PDOWN, MODE_PSAVE, MODE_STBY, MODE_XSTBY,
    MODE_STBY, MODE_ADC};
  localparam logic [6:0] TD [8] = '{DOM_IDLE, DOM_ADC, DOM_PDOWN, DOM_PSAVE, DOM_STBY, DOM_STBY, DOM_PDOWN,
    7'h78};
  localparam logic [8:0] TB [8] = '{9'h000, 9'h044, 9'h001, 9'h008, 9'h004, 9'h040, 9'h001, 9'h040};
  localparam logic [8:0] TG [8] = '{9'h100, 9'h001, 9'h080, 9'h004, 9'h002, 9'h020, 9'h010, 9'h004};
  localparam int TN [8] = '{6, 6, 13, 19, 11, 11, 13, 6};
  assign dom = {timer_osc_en, main_osc_en, async_clk_en, adc_clk_en, io_clk_en, flash_clk_en, cpu_clk_en};
  always #5 aclk = ~aclk;
  smp_sleep_ctrl #(.STARTUP_CYC_0(10), .STARTUP_CYC_1(12), .STARTUP_CYC_2(8), .STARTUP_CYC_3(14),
    .BOD_WAKE_CYCLES(20)) i_smp_sleep_ctrl (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sleep_instr, .wake_src, .sys_reset_req, .timer2_async, .adc_enabled, .bod_fuse_enabled,
    .ext_crystal_sel, .clock_select_fuses, .cpu_clk_en, .flash_clk_en, .io_clk_en, .adc_clk_en,
    .async_clk_en, .main_osc_en, .timer_osc_en, .bod_enable, .adc_conv_start, .core_resume,
    .core_reset_vector);
  smp_core_model i_smp_core_model (.aclk, .aresetn, .core_resume, .core_reset_vector, .sleep_instr,
    .wake_src, .sys_reset_req);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    cmp(bresp, er, "write resp");
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    cmp(rdata, e, "read data");
    cmp(rresp, er, "read resp");
    rready <= 1'b0;
  endtask
  task automatic nap(input logic [2:0] m, input logic se);
    wr(OFF_SLEEP_CTRL, {28'h0, m, se}, RESP_OKAY);
    i_smp_core_model.do_sleep();
    #1;
  endtask
  // cycles from the request edge to the resume or restart pulse
  task automatic wake(input logic [8:0] v, input logic rq, output int n);
    i_smp_core_model.irq(v, rq);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      #1;
    end while (core_resume !== 1'b1 && core_reset_vector !== 1'b1);
  endtask
  task automatic tdone(input string s);
    $display("test %s done, mismatches %0d", s, n_mismatch);
  endtask
  initial begin
    int n;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_SLEEP_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_MCU_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_3f00, RESP_OKAY);
    rd(8'h0c, 32'h0, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(OFF_SLEEP_CTRL, 32'h1, RESP_OKAY);
    rd(OFF_SLEEP_CTRL, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    wr(8'h10, 32'h1, RESP_SLVERR);
    cmp(bod_enable, 1'b1, "bod after reset");
    tdone("reset");
    nap(MODE_PDOWN, 1'b0);
    cmp(cpu_clk_en, 1'b1, "nop sleep cpu");
    cmp(dom, 7'h3f, "nop sleep domains");
    tdone("nop");
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      ext_crystal_sel <= (i != 6);
      timer2_async <= (i == 7);
      adc_enabled <= (i != 7);
      clock_select_fuses <= 2'(i);
      nap(TM[i], 1'b1);
      cmp(dom, TD[i], "sleep domains");
      cmp(adc_conv_start, (TM[i] <= MODE_ADC) && (i != 7), "conversion start");
      if (i == 2) rd(OFF_STATUS, 32'h0000_0021, RESP_OKAY);
      i_smp_core_model.irq(TB[i], 1'b0);
      repeat (4) @(posedge aclk);
      #1;
      cmp(cpu_clk_en, 1'b0, "refused source");
      wake(TG[i], 1'b0, n);
      cmp(n, TN[i], "wake time");
      cmp(cpu_clk_en, 1'b1, "cpu back");
    end
    rd(OFF_SLEEP_CTRL, 32'h0000_0003, RESP_OKAY);
    clock_select_fuses <= 2'h1;
    tdone("modes");
    nap(MODE_PDOWN, 1'b1);
    wake(9'h000, 1'b1, n);
    cmp(n, 13, "reset wake time");
    cmp(core_reset_vector, 1'b1, "reset vector");
    tdone("reset wake");
    wr(OFF_MCU_CTRL, 32'h40, RESP_OKAY);
    rd(OFF_MCU_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_MCU_CTRL, 32'h60, RESP_OKAY);
    wr(OFF_MCU_CTRL, 32'h40, RESP_OKAY);
    rd(OFF_MCU_CTRL, 32'h40, RESP_OKAY);
    clock_select_fuses <= 2'h0;
    nap(MODE_IDLE, 1'b1);
    cmp(bod_enable, 1'b1, "bod kept in idle");
    wake(9'h100, 1'b0, n);
    cmp(n, 6, "idle wake time");
    nap(MODE_PDOWN, 1'b1);
    cmp(bod_enable, 1'b0, "bod off in sleep");
    rd(OFF_STATUS, 32'h0000_0029, RESP_OKAY);
    wake(9'h010, 1'b0, n);
    cmp(n, 25, "bod wake time");
    cmp(bod_enable, 1'b1, "bod back");
    @(posedge aclk);
    bod_fuse_enabled <= 1'b0;
    nap(MODE_PDOWN, 1'b1);
    cmp(bod_enable, 1'b0, "bod fuse off");
    rd(OFF_STATUS, 32'h0000_0021, RESP_OKAY);
    wake(9'h080, 1'b0, n);
    cmp(n, 15, "fuse off wake time");
    tdone("brownout");
    conclude();
  end
endmodule
